// >>> include/tbg_pkg.sv
package tbg_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ------------------------------------------------------------
   localparam logic [7:0] TBG_CTRL_OFS = 8'h00;
   localparam logic [7:0] TBG_CNT_LO_OFS = 8'h04;
   localparam logic [7:0] TBG_CNT_HI_OFS = 8'h08;
   localparam logic [7:0] TBG_RLD_LO_OFS = 8'h0c;
   localparam logic [7:0] TBG_RLD_HI_OFS = 8'h10;
   localparam logic [7:0] TBG_STATUS_OFS = 8'h14;
   localparam logic [7:0] TBG_MASK_OFS = 8'h18;

   // ------------------------------------------------------------
   // Control register field positions
   // ------------------------------------------------------------
   localparam int TBG_CTRL_CAPRLD_BIT = 0;
   localparam int TBG_CTRL_SRC_BIT = 1;
   localparam int TBG_CTRL_RUN_BIT = 2;
   localparam int TBG_CTRL_EXTEN_BIT = 3;
   localparam int TBG_CTRL_TXSEL_BIT = 4;
   localparam int TBG_CTRL_RXSEL_BIT = 5;
   localparam int TBG_CTRL_EXTF_BIT = 6;
   localparam int TBG_CTRL_OVF_BIT = 7;

   // ------------------------------------------------------------
   // Status and mask field positions
   // ------------------------------------------------------------
   localparam int TBG_ST_OVF_BIT = 0;
   localparam int TBG_ST_EXTF_BIT = 1;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [5:0] TBG_CTRL_RST = 6'h00;
   localparam logic [15:0] TBG_CNT_RST = 16'h0000;
   localparam logic [15:0] TBG_RLD_RST = 16'h0000;
   localparam logic [1:0] TBG_STATUS_RST = 2'h0;
   localparam logic [1:0] TBG_MASK_RST = 2'h0;

   // ------------------------------------------------------------
   // Timing counts: prescale in oscillator (pclk) cycles, baud divide in overflows
   // ------------------------------------------------------------
   localparam int TBG_MACH_DIV = 12;
   localparam int TBG_STATE_DIV = 2;
   localparam int TBG_BAUD_DIV = 16;
   localparam logic [3:0] TBG_MACH_LAST = 4'(TBG_MACH_DIV - 1);
   localparam logic [15:0] TBG_CNT_MAX = 16'hffff;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TBG_MODE_OFF = 2'b00,
      TBG_MODE_RELOAD = 2'b01,
      TBG_MODE_CAPTURE = 2'b10,
      TBG_MODE_BAUD = 2'b11
   } tbg_mode_e;

   typedef struct packed {
      logic rx_clock_select;
      logic tx_clock_select;
      logic ext_trigger_enable;
      logic run_control;
      logic count_source_select;
      logic capture_reload_select;
   } tbg_ctrl_s;

   typedef struct packed {
      logic tx_bit_tick;
      logic rx_bit_tick;
      logic tx_sample_tick;
      logic rx_sample_tick;
   } tbg_baud_s;

endpackage

// >>> hdl/tbg_pulse_div.sv
`timescale 1ns/1ps
module tbg_pulse_div #(
   parameter int DIV = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pulse stream
   input wire logic in_pulse,
   output logic out_pulse
);

   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_q;
   logic out_q;
   wire at_last = (cnt_q == LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else begin
         out_q <= in_pulse & at_last;
         if (in_pulse) begin
            cnt_q <= at_last ? '0 : cnt_q + W'(1);
         end
      end
   end

   assign out_pulse = out_q;

endmodule

// >>> hdl/tbg_timer.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// Contract
// - Transmit baud source: first timer overflow when select is 0, ours when 1.
// - Receive select chooses receive baud source the same way, independently.
// - Baud mode high-byte rollover reloads counter from reload high/low bytes.
// - Serial bit rate equals this timer's overflow rate divided by 16.
// - Timer counts once per 12 oscillator cycles; baud mode every 2.
// - Internal baud rate is osc over 32 times (65536 minus reload).
// - Baud mode may count count-pin edges; bit rate is overflow rate / 16.
// - Baud mode rollover sets no overflow flag and raises no interrupt.
// - Baud mode trigger edge sets trigger flag but never reloads counter.
// - Mode: off unless running; baud if any select; else capture or reload.
// - Trigger disabled: reload happens only on overflow; capture mode never captures.
// - Trigger enabled outside baud: overflow and trigger falling edge both act.
// - Count source select: 0 internal osc/12 (osc/2 in baud mode), 1 falling edges of count pin.
// - Trigger enable 0 makes the timer ignore the trigger input.
module tbg_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic count_input_pin,
   input wire logic trigger_input,
   // First timer overflow pulses
   input wire logic timer1_overflow,
   // Serial port clocking
   output tbg_pkg::tbg_baud_s baud,
   // Interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   tbg_pkg::tbg_ctrl_s ctrl_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] rld_q;
   logic [15:0] rld_d;
   logic [1:0] status_q;
   logic [1:0] status_d;
   logic [1:0] mask_q;
   logic [3:0] pre_q;
   logic pin_q;
   logic trig_q;
   logic [31:0] rdata_q;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire sel_ctrl = (paddr == tbg_pkg::TBG_CTRL_OFS);
   wire sel_cnt_lo = (paddr == tbg_pkg::TBG_CNT_LO_OFS);
   wire sel_cnt_hi = (paddr == tbg_pkg::TBG_CNT_HI_OFS);
   wire sel_rld_lo = (paddr == tbg_pkg::TBG_RLD_LO_OFS);
   wire sel_rld_hi = (paddr == tbg_pkg::TBG_RLD_HI_OFS);
   wire sel_status = (paddr == tbg_pkg::TBG_STATUS_OFS);
   wire sel_mask = (paddr == tbg_pkg::TBG_MASK_OFS);
   wire mapped = sel_ctrl | sel_cnt_lo | sel_cnt_hi | sel_rld_lo | sel_rld_hi | sel_status | sel_mask;
   wire wr = access & pwrite & mapped;
   wire wr_ctrl = wr & sel_ctrl;
   wire wr_cnt_lo = wr & sel_cnt_lo;
   wire wr_cnt_hi = wr & sel_cnt_hi;
   wire wr_rld_lo = wr & sel_rld_lo;
   wire wr_rld_hi = wr & sel_rld_hi;
   wire wr_status = wr & sel_status;
   wire wr_mask = wr & sel_mask;

   // ------------------------------------------------------------
   // Mode selection
   // ------------------------------------------------------------
   tbg_pkg::tbg_mode_e mode;
   wire any_sel = ctrl_q.tx_clock_select | ctrl_q.rx_clock_select;

   assign mode = !ctrl_q.run_control ? tbg_pkg::TBG_MODE_OFF :
                 any_sel ? tbg_pkg::TBG_MODE_BAUD :
                 ctrl_q.capture_reload_select ? tbg_pkg::TBG_MODE_CAPTURE :
                 tbg_pkg::TBG_MODE_RELOAD;

   wire is_baud = (mode == tbg_pkg::TBG_MODE_BAUD);
   wire is_capture = (mode == tbg_pkg::TBG_MODE_CAPTURE);
   wire is_reload = (mode == tbg_pkg::TBG_MODE_RELOAD);

   // ------------------------------------------------------------
   // Count sources
   // ------------------------------------------------------------
   // Machine and state ticks.
   wire mach_tick = (pre_q == tbg_pkg::TBG_MACH_LAST);
   wire state_tick = (pre_q[0] == 1'b1);

   // Pins are taken as synchronous, so one stage suffices for edge finding.
   wire pin_fall = pin_q & ~count_input_pin;
   wire trig_fall = trig_q & ~trigger_input;

   wire int_tick = is_baud ? state_tick : mach_tick;
   // External edges also clock baud mode.
   wire src_tick = ctrl_q.count_source_select ? pin_fall : int_tick;
   wire inc = (mode != tbg_pkg::TBG_MODE_OFF) & src_tick;
   wire rollover = inc & (cnt_q == tbg_pkg::TBG_CNT_MAX);

   wire trig_evt = ctrl_q.ext_trigger_enable & trig_fall & (mode != tbg_pkg::TBG_MODE_OFF);

   wire ovf_reload = rollover & (is_reload | is_baud);
   // Trigger edge reloads in reload mode.
   wire trig_reload = trig_evt & is_reload;
   // Trigger edge captures in capture mode.
   wire trig_capture = trig_evt & is_capture;
   // No overflow flag in baud mode.
   wire ovf_flag_set = rollover & ~is_baud;
   // Baud trigger only sets the flag.
   wire extf_set = trig_evt;

   // ------------------------------------------------------------
   // Counter and reload next values
   // ------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      if (inc) begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (ovf_reload || trig_reload) begin
         cnt_d = rld_q;
      end
      if (wr_cnt_lo) begin
         cnt_d[7:0] = pwdata[7:0];
      end
      if (wr_cnt_hi) begin
         cnt_d[15:8] = pwdata[7:0];
      end
   end

   always_comb begin
      rld_d = rld_q;
      if (trig_capture) begin
         rld_d = cnt_q;
      end
      if (wr_rld_lo) begin
         rld_d[7:0] = pwdata[7:0];
      end
      if (wr_rld_hi) begin
         rld_d[15:8] = pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Sticky status
   // ------------------------------------------------------------
   wire [1:0] st_set = {extf_set, ovf_flag_set};
   wire [1:0] st_clr = wr_status ? pwdata[1:0] : 2'h0;

   // Hardware only sets; a set in the clearing cycle wins.
   assign status_d = (status_q & ~st_clr) | st_set;

   assign irq = |(status_q & mask_q);

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   wire [7:0] ctrl_rd = {status_q[tbg_pkg::TBG_ST_OVF_BIT], status_q[tbg_pkg::TBG_ST_EXTF_BIT], ctrl_q};
   wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_rd} :
                        sel_cnt_lo ? {24'h000000, cnt_q[7:0]} :
                        sel_cnt_hi ? {24'h000000, cnt_q[15:8]} :
                        sel_rld_lo ? {24'h000000, rld_q[7:0]} :
                        sel_rld_hi ? {24'h000000, rld_q[15:8]} :
                        sel_status ? {30'h0, status_q} :
                        sel_mask ? {30'h0, mask_q} :
                        32'h00000000;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= tbg_pkg::TBG_CTRL_RST;
         mask_q <= tbg_pkg::TBG_MASK_RST;
         status_q <= tbg_pkg::TBG_STATUS_RST;
      end else begin
         status_q <= status_d;
         if (wr_ctrl) begin
            ctrl_q <= pwdata[5:0];
         end
         if (wr_mask) begin
            mask_q <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= tbg_pkg::TBG_CNT_RST;
         rld_q <= tbg_pkg::TBG_RLD_RST;
      end else begin
         cnt_q <= cnt_d;
         rld_q <= rld_d;
      end
   end

   // Prescaler runs free so the machine cycle phase does not depend on the run bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 4'h0;
      end else begin
         pre_q <= mach_tick ? 4'h0 : pre_q + 4'h1;
      end
   end

   // Edge history starts low so no falling edge can be seen in the first cycle after release.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         pin_q <= count_input_pin;
         trig_q <= trigger_input;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h00000000;
      end else if (setup) begin
         rdata_q <= rd_mux;
      end
   end

   // No wait state; read data is registered in the setup phase so it comes from a flip-flop.
   assign pready = penable;
   assign pslverr = access & ~mapped;
   assign prdata = rdata_q;

   // ------------------------------------------------------------
   // Serial port clocking
   // ------------------------------------------------------------
   // Only baud mode overflows feed the serial port; a set select with the timer off gives no ticks.
   wire own_ovf = rollover & is_baud;

   wire tx_src = ctrl_q.tx_clock_select ? own_ovf : timer1_overflow;
   wire rx_src = ctrl_q.rx_clock_select ? own_ovf : timer1_overflow;

   logic tx_src_q;
   logic rx_src_q;
   logic tx_bit;
   logic rx_bit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_src_q <= 1'b0;
         rx_src_q <= 1'b0;
      end else begin
         tx_src_q <= tx_src;
         rx_src_q <= rx_src;
      end
   end

   // Bit tick is overflow rate over 16.
   tbg_pulse_div #(.DIV(tbg_pkg::TBG_BAUD_DIV)) u_tx_div (
      .pclk(pclk),
      .presetn(presetn),
      .in_pulse(tx_src),
      .out_pulse(tx_bit)
   );

   // With state-time counting this yields osc / (32 x (65536 - reload)).
   tbg_pulse_div #(.DIV(tbg_pkg::TBG_BAUD_DIV)) u_rx_div (
      .pclk(pclk),
      .presetn(presetn),
      .in_pulse(rx_src),
      .out_pulse(rx_bit)
   );

   assign baud = {tx_bit, rx_bit, tx_src_q, rx_src_q};

endmodule

// >>> testbench/tbg_timer_props.sv
`timescale 1ns/1ps
module tbg_timer_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and serial clocking
   input wire logic count_input_pin,
   input wire logic trigger_input,
   input wire logic timer1_overflow,
   input wire tbg_pkg::tbg_baud_s baud,
   input wire logic irq
);
   // ----------------------------------------
   // Shadow of the control bits
   // ----------------------------------------
   // The shadow follows bus writes only, so it stays blind to the flag mirrors.
   logic [5:0] ctl_q;
   wire logic wr_any = psel && penable && pwrite;
   wire logic wr_ctl = wr_any && paddr == tbg_pkg::TBG_CTRL_OFS;
   wire logic wr_msk = wr_any && paddr == tbg_pkg::TBG_MASK_OFS;
   wire logic run = ctl_q[tbg_pkg::TBG_CTRL_RUN_BIT];
   wire logic tsel = ctl_q[tbg_pkg::TBG_CTRL_TXSEL_BIT];
   wire logic rsel = ctl_q[tbg_pkg::TBG_CTRL_RXSEL_BIT];
   wire logic ext = ctl_q[tbg_pkg::TBG_CTRL_EXTEN_BIT];
   wire logic tx_off = !run && tsel;
   wire logic rx_off = !run && rsel;
   wire logic bmode = run && (tsel || rsel);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 6'h00;
      end else if (wr_ctl) begin
         ctl_q <= pwdata[5:0];
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   tx_source_a: assert property (!tsel |=> baud.tx_sample_tick == $past(timer1_overflow))
      else $error("tx sample tick not tied to first timer");
   rx_source_a: assert property (!rsel |=> baud.rx_sample_tick == $past(timer1_overflow))
      else $error("rx sample tick not tied to first timer");
   state_time_a: assert property (bmode && tsel && $past(bmode && tsel) && baud.tx_sample_tick |=>
      !baud.tx_sample_tick || !tsel)
      else $error("baud counter advanced faster than every two cycles");
   tx_stopped_a: assert property (tx_off && $past(tx_off) |-> !baud.tx_sample_tick)
      else $error("tx tick while timer is off");
   rx_stopped_a: assert property (rx_off [*2] |-> !baud.rx_sample_tick)
      else $error("rx tick while timer is off");
   tx_bit_a: assert property (baud.tx_bit_tick |-> baud.tx_sample_tick)
      else $error("tx bit tick off the overflow grid");
   rx_bit_a: assert property ($rose(baud.rx_bit_tick) |-> baud.rx_sample_tick)
      else $error("rx bit tick off the overflow grid");
   irq_cause_a: assert property ($rose(irq) && bmode && $past(bmode) |->
      $past(wr_msk) || ($past(ext) && $past(trigger_input, 2) && !$past(trigger_input)))
      else $error("interrupt rose in baud mode without trigger edge");
endmodule

bind tbg_timer tbg_timer_props u_tbg_timer_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .count_input_pin(count_input_pin), .trigger_input(trigger_input),
   .timer1_overflow(timer1_overflow), .baud(baud), .irq(irq)
);

// >>> testbench/tbg_serial_model.sv
`timescale 1ns/1ps
module tbg_serial_model #(
   parameter int T1_PERIOD = 5
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Timer side
   input wire tbg_pkg::tbg_baud_s baud,
   output logic timer1_overflow,
   // Bits clocked by the serial port
   output logic [15:0] tx_bits,
   output logic [15:0] rx_bits
);
   // ----------------------------------------
   // First timer and bit clocks
   // ----------------------------------------
   // A steady first timer keeps the rate it hands over easy to predict.
   logic [3:0] pre_q;
   assign timer1_overflow = (pre_q == 4'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 4'h0;
         tx_bits <= 16'h0000;
         rx_bits <= 16'h0000;
      end else begin
         pre_q <= (pre_q == 4'(T1_PERIOD - 1)) ? 4'h0 : pre_q + 4'h1;
         tx_bits <= tx_bits + {15'h0, baud.tx_bit_tick};
         rx_bits <= rx_bits + {15'h0, baud.rx_bit_tick};
      end
   end
endmodule

// >>> testbench/tbg_timer_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module tbg_timer_tb;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic count_input_pin = 1'b0, trigger_input = 1'b1, pready, pslverr, timer1_overflow, irq, slv_err;
   logic [1:0] pin_q = 2'h0;
   logic [15:0] tx_bits, rx_bits, tx0, rx0;
   tbg_pkg::tbg_baud_s baud;
   int fail_count = 0, tests_run = 0;
   logic [7:0] cfg [5] = '{8'h34, 8'h24, 8'h14, 8'h36, 8'h30};
   logic [7:0] rld [5] = '{8'hff, 8'hfe, 8'hfe, 8'hff, 8'hff};
   logic [15:0] ex_tx [5] = '{16'h0014, 16'h0008, 16'h000a, 16'h000a, 16'h0000};
   logic [15:0] ex_rx [5] = '{16'h0014, 16'h000a, 16'h0008, 16'h000a, 16'h0000};
   tbg_timer u_tbg_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_input_pin(count_input_pin), .trigger_input(trigger_input),
      .timer1_overflow(timer1_overflow), .baud(baud), .irq(irq));
   tbg_serial_model u_tbg_serial_model (.pclk(pclk), .presetn(presetn), .baud(baud),
      .timer1_overflow(timer1_overflow), .tx_bits(tx_bits), .rx_bits(rx_bits));
   always #4 pclk = ~pclk;
   // The count pin falls once every four cycles, slow enough for edge detection.
   always @(posedge pclk) begin
      pin_q <= pin_q + 2'h1;
      count_input_pin <= pin_q[1];
   end
   task automatic close_out();
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 16) begin
            fail_count++;
            close_out();
         end
         @(posedge pclk);
      end
      r = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      acc(1'b1, a, {24'h000000, d}, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      acc(1'b0, a, 32'h0000_0000, r);
      `CHK($sformatf("reg %h", a), {24'h000000, e}, r)
   endtask
   task automatic fall();
      trigger_input <= 1'b0;
      cyc(3);
      trigger_input <= 1'b1;
      cyc(2);
   endtask
   task automatic rate(input int i);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h00);
      wr(tbg_pkg::TBG_RLD_LO_OFS, rld[i]);
      wr(tbg_pkg::TBG_RLD_HI_OFS, 8'hff);
      wr(tbg_pkg::TBG_CNT_LO_OFS, 8'hff);
      wr(tbg_pkg::TBG_CNT_HI_OFS, 8'hff);
      wr(tbg_pkg::TBG_CTRL_OFS, cfg[i]);
      cyc(128);
      #1;
      tx0 = tx_bits;
      rx0 = rx_bits;
      cyc(640);
      #1;
      `CHK("tx bits", ex_tx[i], 16'(tx_bits - tx0))
      `CHK("rx bits", ex_rx[i], 16'(rx_bits - rx0))
      @(posedge pclk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      int n;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         rd(8'(4 * i), 8'h00);
      end
      `CHK("slave error", 1'b1, slv_err)
      for (int i = 0; i < 5; i++) begin
         rate(i);
      end
      wr(tbg_pkg::TBG_MASK_OFS, 8'h03);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h3c);
      cyc(200);
      rd(tbg_pkg::TBG_STATUS_OFS, 8'h00);
      `CHK("irq", 1'b0, irq)
      fall();
      rd(tbg_pkg::TBG_STATUS_OFS, 8'h02);
      rd(tbg_pkg::TBG_CTRL_OFS, 8'h7c);
      `CHK("irq", 1'b1, irq)
      wr(tbg_pkg::TBG_MASK_OFS, 8'h00);
      `CHK("irq", 1'b0, irq)
      wr(tbg_pkg::TBG_MASK_OFS, 8'h03);
      wr(tbg_pkg::TBG_STATUS_OFS, 8'h02);
      rd(tbg_pkg::TBG_STATUS_OFS, 8'h00);
      `CHK("irq", 1'b0, irq)
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h34);
      fall();
      rd(tbg_pkg::TBG_STATUS_OFS, 8'h00);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h00);
      wr(tbg_pkg::TBG_RLD_LO_OFS, 8'h34);
      wr(tbg_pkg::TBG_RLD_HI_OFS, 8'h12);
      wr(tbg_pkg::TBG_CNT_LO_OFS, 8'hfe);
      wr(tbg_pkg::TBG_CNT_HI_OFS, 8'hff);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h04);
      n = 0;
      r = 32'h0000_0000;
      while (r[0] !== 1'b1 && n < 20) begin
         acc(1'b0, tbg_pkg::TBG_STATUS_OFS, 32'h0000_0000, r);
         n++;
      end
      if (r[0] !== 1'b1) begin
         fail_count++;
         close_out();
      end
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h00);
      rd(tbg_pkg::TBG_CNT_HI_OFS, 8'h12);
      rd(tbg_pkg::TBG_CNT_LO_OFS, 8'h34);
      rd(tbg_pkg::TBG_CTRL_OFS, 8'h80);
      wr(tbg_pkg::TBG_CNT_HI_OFS, 8'h00);
      wr(tbg_pkg::TBG_STATUS_OFS, 8'h03);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h0c);
      fall();
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h00);
      rd(tbg_pkg::TBG_CNT_HI_OFS, 8'h12);
      rd(tbg_pkg::TBG_STATUS_OFS, 8'h02);
      wr(tbg_pkg::TBG_CNT_HI_OFS, 8'h00);
      wr(tbg_pkg::TBG_STATUS_OFS, 8'h03);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h04);
      fall();
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h00);
      rd(tbg_pkg::TBG_CNT_HI_OFS, 8'h00);
      rd(tbg_pkg::TBG_STATUS_OFS, 8'h00);
      wr(tbg_pkg::TBG_CNT_HI_OFS, 8'h56);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h09);
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h0d);
      fall();
      wr(tbg_pkg::TBG_CTRL_OFS, 8'h00);
      rd(tbg_pkg::TBG_RLD_HI_OFS, 8'h56);
      rd(tbg_pkg::TBG_CNT_HI_OFS, 8'h56);
      close_out();
   end
endmodule
